// >>> hbridge_prot_pkg.sv
package hbridge_prot_pkg;
   // Register offsets
   localparam logic [6:0] ADDR_GEN = 7'h16;
   localparam logic [6:0] ADDR_WAKE = 7'h31;
   localparam logic [6:0] ADDR_CFG = 7'h3f;
   // Field positions
   localparam int GEN_EN_BIT = 0;
   localparam int WAKE_OV_BIT = 0;
   localparam int CFG_DUAL_A_BIT = 0;
   localparam int CFG_DUAL_B_BIT = 1;
   localparam int CFG_FORCE_BIT = 4;
   // Reset values
   localparam logic [23:0] GEN_RST = 24'h000001;
   localparam logic [23:0] CFG_RST = 24'h000000;
   localparam logic [23:0] WAKE_RST = 24'h000000;
   // Slew step divisor
   localparam int SLEW_DIV = 31;
   // Timing
   localparam int CLK_MHZ = 100;
   localparam int RL_SINK_US = 32;
   localparam int RL_SINK_CYC = RL_SINK_US * CLK_MHZ;
endpackage

// >>> hbridge_gate_protection_ctrl.sv
`timescale 1ns/100ps
// Function
// - Gate current equals slew code times step
// - Slew code zero selects low-impedance switch
// - Current source only below switch threshold
// - Resistive mode on standby or failures
// - Failure entry sinks 32us then resistive
// - Sink phase slew controlled when enabled
// - Overlong drain-source overvoltage trips driver, flags
// - Tripped driver off until flag cleared, except low sides while braking
// - Monitoring only while on, bounded by filter
// - Settling masks result, filter may start
// - Off-state test enters resistive low
// - Low drain-source in test sets flag
// - Two low-side flags, inverted comparator sense
// - Off-state test only in single mode
// - Cross-current delay before each switch-on, except low sides while braking
// - PWM uses two equal locking timers
// - Manchester failure lines turn sinks on
// - Standby turns sinks on, decoder stopped
// - Sink current limit trips, flag cleared
// - Force bit turns both sinks on
// - Generator overvoltage turns all low sides on
// - Generator enable resets on, wake bit
// - Braking releases when overvoltage ends
module hbridge_gate_protection_ctrl #(
   parameter int DS_FILT_CYC = 600,
   parameter int DS_SETTLE_CYC = 200,
   parameter int OL_FILT_CYC = 2000,
   parameter int FSO_FILT_CYC = 1000,
   parameter int LOCK_STEP_CYC = 25,
   parameter int MAN_HALF_CYC = 50,
   parameter int I_MAX_UA = 31000
) (
   input wire logic i_mclk,
   input wire logic i_sys_rst,
   input wire logic i_ce,
   input wire logic i_reg_wr,
   input wire logic i_reg_rd,
   input wire logic [6:0] i_reg_addr,
   input wire logic [23:0] i_reg_wdata,
   output logic [23:0] o_reg_rdata,
   input wire logic i_standby,
   input wire logic i_thermal_shutdown_one,
   input wire logic i_pump_low_flag,
   input wire logic i_invalid_command_flag,
   input wire logic i_vs_ov,
   input wire logic [1:0] i_bridge_enable_bit,
   input wire logic [1:0] i_offstate_test_h1_l2,
   input wire logic [1:0] i_offstate_test_h2_l1,
   input wire logic [1:0] i_pwm_mode,
   input wire logic [1:0] i_bridge_pwm_input,
   input wire logic [1:0][4:0] i_slew_code,
   input wire logic [3:0] i_bridge_a_lock_time,
   input wire logic [3:0] i_bridge_b_lock_time,
   input wire logic [7:0] i_drv_cmd,
   input wire logic [7:0] i_ds_over,
   input wire logic [7:0] i_ds_low,
   input wire logic [7:0] i_vds_below_sw,
   input wire logic [7:0] i_ds_clr,
   input wire logic [3:0] i_fs_line,
   input wire logic [1:0] i_fso_ilim,
   input wire logic [1:0] i_fso_oc_clr,
   output logic [7:0] o_gate_on,
   output logic [7:0] o_hs_src_on,
   output logic [1:0][15:0] o_hs_cur_ua,
   output logic [1:0] o_rl_sink,
   output logic [1:0] o_rl_resistive,
   output logic [1:0] o_sink_slew,
   output logic [7:0] o_ds_monitor_flag,
   output logic [1:0] o_fso_on,
   output logic [1:0] o_safety_sink_overcurrent
);
   typedef enum logic [2:0] {PW_HS_ON, PW_HS_OFF_LK, PW_LS_LK, PW_LS_ON, PW_HS_LK} pwm_st_t;

   localparam int MAN_MID = (3 * MAN_HALF_CYC) / 2;
   localparam int MAN_TMO = 4 * MAN_HALF_CYC;
   localparam int SLEW_STEP_UA = I_MAX_UA / hbridge_prot_pkg::SLEW_DIV;

   logic [23:0] gen_ff, cfg_ff, wake_ff;
   logic [1:0] fail_q_ff, sink_ff, res_ff, sink_slew_ff;
   logic [1:0][15:0] rl_cnt_ff, pwm_cnt_ff, cur_ff;
   pwm_st_t [1:0] pwm_st_ff;
   logic [7:0] gate_ff, src_ff, flag_ff;
   logic [7:0][15:0] ccd_cnt_ff, filt_ff, age_ff;
   logic [3:0] line_q_ff, data_ff;
   logic [3:0][15:0] run_ff;
   logic [1:0] fso_ff, oc_ff;
   logic [1:0][15:0] oc_cnt_ff;
   logic fail, brake, gen_en, fs_fail, force_on;
   logic [1:0] dual, ost, rl_req, pwm_hs, pwm_ls, nxt_sink;
   logic [7:0] ok, nxt_gate;

   // Lock time in cycles from a 4-bit code
   function automatic logic [15:0] lock_cyc(input logic [3:0] c);
      return 16'(int'(c) * LOCK_STEP_CYC);
   endfunction

   function automatic logic [3:0] lock_of(input int b);
      return (b == 0) ? i_bridge_a_lock_time : i_bridge_b_lock_time;
   endfunction

   // Common conditions
   assign gen_en = gen_ff[hbridge_prot_pkg::GEN_EN_BIT];
   assign force_on = cfg_ff[hbridge_prot_pkg::CFG_FORCE_BIT];
   assign dual = {cfg_ff[hbridge_prot_pkg::CFG_DUAL_B_BIT], cfg_ff[hbridge_prot_pkg::CFG_DUAL_A_BIT]};
   assign fail = i_thermal_shutdown_one | i_pump_low_flag | i_invalid_command_flag;
   assign brake = gen_en & i_vs_ov & ~i_standby;
   assign ost = i_bridge_enable_bit & (i_offstate_test_h1_l2 | i_offstate_test_h2_l1) & ~dual;
   assign rl_req = {2{i_standby | fail}} | ~i_bridge_enable_bit | ost;
   assign fs_fail = |data_ff;

   // Register port; status read clears, a new wake event in the same cycle wins
   always_ff @(posedge i_mclk) begin
      if (i_sys_rst) begin
         gen_ff <= hbridge_prot_pkg::GEN_RST;
         cfg_ff <= hbridge_prot_pkg::CFG_RST;
         wake_ff <= hbridge_prot_pkg::WAKE_RST;
         o_reg_rdata <= 24'h000000;
      end else if (i_ce) begin
         if (i_reg_wr && i_reg_addr == hbridge_prot_pkg::ADDR_GEN) begin
            gen_ff <= i_reg_wdata;
         end
         if (i_reg_wr && i_reg_addr == hbridge_prot_pkg::ADDR_CFG) begin
            cfg_ff <= i_reg_wdata;
         end
         if (i_reg_rd && i_reg_addr == hbridge_prot_pkg::ADDR_WAKE) begin
            wake_ff <= 24'h000000;
         end
         if (i_standby && gen_en && i_vs_ov) begin
            wake_ff[hbridge_prot_pkg::WAKE_OV_BIT] <= 1'b1;
         end
         if (i_reg_rd) begin
            unique case (i_reg_addr)
               hbridge_prot_pkg::ADDR_GEN: o_reg_rdata <= gen_ff;
               hbridge_prot_pkg::ADDR_WAKE: o_reg_rdata <= wake_ff;
               hbridge_prot_pkg::ADDR_CFG: o_reg_rdata <= cfg_ff;
               default: o_reg_rdata <= 24'h000000;
            endcase
         end
      end
   end

   // Next sink state; resistive and slew flops follow it so no resistive glitch precedes the sink
   always_comb begin
      for (int b = 0; b < 2; b++) begin
         nxt_sink[b] = (fail & ~fail_q_ff[b]) | (rl_cnt_ff[b] != 16'h0000);
      end
   end

   // Resistive-low entry: a failure edge starts a fixed active sink phase
   always_ff @(posedge i_mclk) begin
      if (i_sys_rst) begin
         fail_q_ff <= 2'h0;
         sink_ff <= 2'h0;
         res_ff <= 2'h3;
         sink_slew_ff <= 2'h0;
         rl_cnt_ff <= '0;
      end else if (i_ce) begin
         for (int b = 0; b < 2; b++) begin
            fail_q_ff[b] <= fail;
            if (fail && !fail_q_ff[b]) begin
               rl_cnt_ff[b] <= 16'(hbridge_prot_pkg::RL_SINK_CYC - 1);
            end else if (rl_cnt_ff[b] != 16'h0000) begin
               rl_cnt_ff[b] <= rl_cnt_ff[b] - 16'h0001;
            end
            sink_ff[b] <= nxt_sink[b];
            res_ff[b] <= rl_req[b] & ~nxt_sink[b];
            sink_slew_ff[b] <= nxt_sink[b] & (i_slew_code[b] != 5'h00);
         end
      end
   end

   // PWM locking: both lock timers use the same programmed time
   always_comb begin
      for (int b = 0; b < 2; b++) begin
         pwm_hs[b] = pwm_st_ff[b] == PW_HS_ON || pwm_st_ff[b] == PW_HS_OFF_LK;
         pwm_ls[b] = pwm_st_ff[b] == PW_LS_ON;
      end
   end

   always_ff @(posedge i_mclk) begin
      if (i_sys_rst) begin
         pwm_st_ff <= '{default: PW_LS_LK};
         pwm_cnt_ff <= '0;
      end else if (i_ce) begin
         for (int b = 0; b < 2; b++) begin
            pwm_cnt_ff[b] <= pwm_cnt_ff[b] + 16'h0001;
            if (!i_pwm_mode[b]) begin
               pwm_st_ff[b] <= PW_LS_LK;
               pwm_cnt_ff[b] <= 16'h0000;
            end else begin
               unique case (pwm_st_ff[b])
                  PW_HS_ON: begin
                     pwm_cnt_ff[b] <= 16'h0000;
                     if (!i_bridge_pwm_input[b]) begin
                        pwm_st_ff[b] <= PW_HS_OFF_LK;
                     end
                  end
                  PW_HS_OFF_LK: begin
                     if (i_bridge_pwm_input[b]) begin
                        pwm_st_ff[b] <= PW_HS_ON;
                     end else if (pwm_cnt_ff[b] >= lock_cyc(lock_of(b))) begin
                        pwm_st_ff[b] <= PW_LS_LK;
                        pwm_cnt_ff[b] <= 16'h0000;
                     end
                  end
                  PW_LS_LK: begin
                     if (i_bridge_pwm_input[b]) begin
                        pwm_st_ff[b] <= PW_HS_LK;
                        pwm_cnt_ff[b] <= 16'h0000;
                     end else if (pwm_cnt_ff[b] >= lock_cyc(lock_of(b))) begin
                        pwm_st_ff[b] <= PW_LS_ON;
                     end
                  end
                  PW_LS_ON: begin
                     pwm_cnt_ff[b] <= 16'h0000;
                     if (i_bridge_pwm_input[b]) begin
                        pwm_st_ff[b] <= PW_HS_LK;
                     end
                  end
                  PW_HS_LK: begin
                     if (!i_bridge_pwm_input[b]) begin
                        pwm_st_ff[b] <= PW_LS_LK;
                        pwm_cnt_ff[b] <= 16'h0000;
                     end else if (pwm_cnt_ff[b] >= lock_cyc(lock_of(b))) begin
                        pwm_st_ff[b] <= PW_HS_ON;
                     end
                  end
               endcase
            end
         end
      end
   end

   // Cross-current delay counts from the internal switch-on command
   always_ff @(posedge i_mclk) begin
      if (i_sys_rst) begin
         ccd_cnt_ff <= '0;
      end else if (i_ce) begin
         for (int d = 0; d < 8; d++) begin
            if (!i_drv_cmd[d]) begin
               ccd_cnt_ff[d] <= 16'h0000;
            end else if (ccd_cnt_ff[d] < lock_cyc(lock_of(d / 4))) begin
               ccd_cnt_ff[d] <= ccd_cnt_ff[d] + 16'h0001;
            end
         end
      end
   end

   // Gate decision; braking overrides every protection on the low sides
   always_comb begin
      for (int d = 0; d < 8; d++) begin
         if (i_pwm_mode[d / 4] && (d % 4) < 2) begin
            ok[d] = d[0] ? pwm_ls[d / 4] : pwm_hs[d / 4];
         end else begin
            ok[d] = i_drv_cmd[d] && ccd_cnt_ff[d] >= lock_cyc(lock_of(d / 4));
         end
         nxt_gate[d] = (brake & d[0])
            | (~rl_req[d / 4] & ~sink_ff[d / 4] & ok[d] & ~flag_ff[d]);
      end
   end

   // Drive outputs and slew-rate current source selection
   always_ff @(posedge i_mclk) begin
      if (i_sys_rst) begin
         gate_ff <= 8'h00;
         src_ff <= 8'h00;
         cur_ff <= '0;
      end else if (i_ce) begin
         gate_ff <= nxt_gate;
         for (int d = 0; d < 8; d++) begin
            src_ff[d] <= !d[0] && gate_ff[d] && i_slew_code[d / 4] != 5'h00 && i_vds_below_sw[d];
         end
         for (int b = 0; b < 2; b++) begin
            cur_ff[b] <= 16'(int'(i_slew_code[b]) * SLEW_STEP_UA);
         end
      end
   end

   // One filter counter per driver serves on-state and off-state checks
   always_ff @(posedge i_mclk) begin
      if (i_sys_rst) begin
         filt_ff <= '0;
         age_ff <= '0;
         flag_ff <= 8'h00;
      end else if (i_ce) begin
         for (int d = 0; d < 8; d++) begin
            if (!gate_ff[d]) begin
               age_ff[d] <= 16'h0000;
            end else if (age_ff[d] < 16'(DS_SETTLE_CYC)) begin
               age_ff[d] <= age_ff[d] + 16'h0001;
            end
            if (gate_ff[d] ? i_ds_over[d] : (ost[d / 4] & d[0] & i_ds_low[d])) begin
               filt_ff[d] <= filt_ff[d] + 16'h0001;
            end else begin
               filt_ff[d] <= 16'h0000;
            end
            // Set beats a clear arriving in the same cycle
            flag_ff[d] <= (flag_ff[d] & ~i_ds_clr[d])
               | (gate_ff[d] && filt_ff[d] >= 16'(DS_FILT_CYC) && age_ff[d] >= 16'(DS_SETTLE_CYC))
               | (!gate_ff[d] && filt_ff[d] >= 16'(OL_FILT_CYC));
         end
      end
   end

   // Manchester check: stuck line or decoded one means failure; idle in standby
   always_ff @(posedge i_mclk) begin
      if (i_sys_rst || (i_ce && i_standby)) begin
         line_q_ff <= 4'h0;
         data_ff <= 4'h0;
         run_ff <= '0;
      end else if (i_ce) begin
         line_q_ff <= i_fs_line;
         for (int k = 0; k < 4; k++) begin
            if (i_fs_line[k] != line_q_ff[k]) begin
               run_ff[k] <= 16'h0000;
               if (run_ff[k] >= 16'(MAN_MID)) begin
                  data_ff[k] <= i_fs_line[k];
               end
            end else if (run_ff[k] >= 16'(MAN_TMO)) begin
               data_ff[k] <= 1'b1;
            end else begin
               run_ff[k] <= run_ff[k] + 16'h0001;
            end
         end
      end
   end

   // Safety sinks with current-limit trip; flag set wins over clear
   always_ff @(posedge i_mclk) begin
      if (i_sys_rst) begin
         fso_ff <= 2'h0;
         oc_ff <= 2'h0;
         oc_cnt_ff <= '0;
      end else if (i_ce) begin
         for (int s = 0; s < 2; s++) begin
            fso_ff[s] <= (fs_fail | i_standby | force_on) & ~oc_ff[s];
            if (fso_ff[s] && i_fso_ilim[s]) begin
               oc_cnt_ff[s] <= oc_cnt_ff[s] + 16'h0001;
            end else begin
               oc_cnt_ff[s] <= 16'h0000;
            end
            oc_ff[s] <= (oc_ff[s] & ~i_fso_oc_clr[s]) | (oc_cnt_ff[s] >= 16'(FSO_FILT_CYC));
         end
      end
   end

   assign o_gate_on = gate_ff;
   assign o_hs_src_on = src_ff;
   assign o_hs_cur_ua = cur_ff;
   assign o_rl_sink = sink_ff;
   assign o_rl_resistive = res_ff;
   assign o_sink_slew = sink_slew_ff;
   assign o_ds_monitor_flag = flag_ff;
   assign o_fso_on = fso_ff;
   assign o_safety_sink_overcurrent = oc_ff;

   default clocking @(posedge i_mclk); endclocking
   default disable iff (i_sys_rst || !i_ce);

   property p_ds_off; flag_ff[0] && !brake |=> !gate_ff[0]; endproperty
   a_ds_off: assert property (p_ds_off) else $error("tripped driver on");
   property p_ds_hold; flag_ff[0] && !i_ds_clr[0] |=> flag_ff[0]; endproperty
   a_ds_hold: assert property (p_ds_hold) else $error("flag lost");
   property p_slew_off; 1 |=> ($past(i_slew_code[0]) != 5'h00 || !src_ff[0]); endproperty
   a_slew_off: assert property (p_slew_off) else $error("source with code 0");
   property p_ost_rl; ost[0] |=> res_ff[0] || sink_ff[0]; endproperty
   a_ost_rl: assert property (p_ost_rl) else $error("test not resistive");
   property p_force; force_on && !oc_ff[1] |=> fso_ff[1]; endproperty
   a_force: assert property (p_force) else $error("force ignored");
   property p_oc; oc_ff[0] |=> !fso_ff[0]; endproperty
   a_oc: assert property (p_oc) else $error("sink on after trip");
   property p_brake; brake |=> gate_ff[1] && gate_ff[3] && gate_ff[5] && gate_ff[7]; endproperty
   a_brake: assert property (p_brake) else $error("brake missing");
   property p_lock; !(pwm_hs[0] && pwm_ls[0]); endproperty
   a_lock: assert property (p_lock) else $error("cross conduction");
   property p_sink; $rose(sink_ff[1]) |-> sink_ff[1] [*8]; endproperty
   a_sink: assert property (p_sink) else $error("sink phase short");

   c_trip: cover property ($rose(flag_ff[0]));
   c_pwm: cover property (pwm_st_ff[0] == PW_LS_ON ##1 pwm_st_ff[0] == PW_HS_LK);
   c_fso: cover property ($rose(oc_ff[0]));
endmodule

// >>> mosfet_far_side.sv
`timescale 1ns/100ps
module mosfet_far_side (
   input wire logic [7:0] i_gate_on,
   input wire logic [7:0] i_short_en,
   input wire logic [7:0] i_low_en,
   input wire logic [7:0] i_slope_done,
   output logic [7:0] o_ds_over,
   output logic [7:0] o_ds_low,
   output logic [7:0] o_vds_below_sw
);
   // A shorted load only shows a large drop while the transistor conducts
   assign o_ds_over = i_gate_on & i_short_en;
   // A faulty load leaves an off transistor below a sixth of supply
   assign o_ds_low = ~i_gate_on & i_low_en;
   // Drop stays under the slew threshold while driven until the bench ends the slope
   assign o_vds_below_sw = i_gate_on & ~i_slope_done;
endmodule

// >>> test_hbridge_gate_protection_ctrl.sv
`timescale 1ns/100ps
module test_hbridge_gate_protection_ctrl;
   localparam int DSF = 8, OLF = 8, FSOF = 8, LSTEP = 2, MHALF = 4, IMAX = 31000;
   logic i_mclk = 1'b0, i_sys_rst = 1'b1, i_ce = 1'b1, i_reg_wr = 1'b0, i_reg_rd = 1'b0, man_en = 1'b1;
   logic i_standby = 1'b0, i_thermal_shutdown_one = 1'b0, i_pump_low_flag = 1'b0;
   logic i_invalid_command_flag = 1'b0, i_vs_ov = 1'b0;
   logic [6:0] i_reg_addr = 7'h00;
   logic [23:0] i_reg_wdata = 24'h0, exp_v, got;
   logic [1:0] i_bridge_enable_bit = 2'h0, i_offstate_test_h1_l2 = 2'h0, i_offstate_test_h2_l1 = 2'h0;
   logic [1:0] i_pwm_mode = 2'h0, i_bridge_pwm_input = 2'h0, i_fso_ilim = 2'h0, i_fso_oc_clr = 2'h0;
   logic [1:0][4:0] i_slew_code = '0;
   logic [3:0] i_bridge_a_lock_time = 4'h0, i_bridge_b_lock_time = 4'h0, i_fs_line = 4'h0;
   logic [7:0] i_drv_cmd = 8'h0, i_ds_clr = 8'h0, short_en = 8'h0, low_en = 8'h0, slope_done = 8'h0;
   logic [7:0] i_ds_over, i_ds_low, i_vds_below_sw, o_gate_on, o_hs_src_on, o_ds_monitor_flag;
   logic [23:0] o_reg_rdata;
   logic [1:0][15:0] o_hs_cur_ua;
   logic [1:0] o_rl_sink, o_rl_resistive, o_sink_slew, o_fso_on, o_safety_sink_overcurrent;
   logic [4:0] code;
   logic [2:0] mph = 3'h0;
   int num_errors = 0, num_checks = 0, sel;
   int sel_q[$];
   logic [23:0] exp_q[$];
   event look;

   hbridge_gate_protection_ctrl #(.DS_FILT_CYC(DSF), .DS_SETTLE_CYC(2), .OL_FILT_CYC(OLF), .FSO_FILT_CYC(FSOF),
      .LOCK_STEP_CYC(LSTEP), .MAN_HALF_CYC(MHALF), .I_MAX_UA(IMAX)) hbridge_gate_protection_ctrl_i (
      .i_mclk, .i_sys_rst, .i_ce, .i_reg_wr, .i_reg_rd, .i_reg_addr, .i_reg_wdata, .o_reg_rdata,
      .i_standby, .i_thermal_shutdown_one, .i_pump_low_flag, .i_invalid_command_flag, .i_vs_ov,
      .i_bridge_enable_bit, .i_offstate_test_h1_l2, .i_offstate_test_h2_l1, .i_pwm_mode, .i_bridge_pwm_input,
      .i_slew_code, .i_bridge_a_lock_time, .i_bridge_b_lock_time, .i_drv_cmd, .i_ds_over, .i_ds_low,
      .i_vds_below_sw, .i_ds_clr, .i_fs_line, .i_fso_ilim, .i_fso_oc_clr, .o_gate_on, .o_hs_src_on,
      .o_hs_cur_ua, .o_rl_sink, .o_rl_resistive, .o_sink_slew, .o_ds_monitor_flag, .o_fso_on,
      .o_safety_sink_overcurrent);

   mosfet_far_side mosfet_far_side_i (.i_gate_on(o_gate_on), .i_short_en(short_en), .i_low_en(low_en),
      .i_slope_done(slope_done),
      .o_ds_over(i_ds_over), .o_ds_low(i_ds_low), .o_vds_below_sw(i_vds_below_sw));

   // Free-running clock
   initial begin
      forever #5 i_mclk = ~i_mclk;
   end

   // Healthy Manchester stream of zeros, half bit of MHALF cycles; stopping it mimics a dead line
   always @(negedge i_mclk) begin
      mph <= mph + 3'h1;
      if (man_en) i_fs_line <= {4{~mph[2]}};
   end

   task automatic tick(input int n);
      repeat (n) @(negedge i_mclk);
   endtask

   // Notes an expectation; the watcher reads the selected output in the same settled step
   task automatic chk(input int s, input logic [23:0] e);
      sel_q.push_back(s);
      exp_q.push_back(e);
      -> look;
   endtask

   task automatic reg_wr(input logic [6:0] a, input logic [23:0] d);
      i_reg_addr = a;
      i_reg_wdata = d;
      i_reg_wr = 1'b1;
      tick(1);
      i_reg_wr = 1'b0;
      tick(1);
   endtask

   // Read data is registered, so it is settled by the following falling edge
   task automatic reg_rd(input logic [6:0] a, input logic [23:0] e);
      i_reg_addr = a;
      i_reg_rd = 1'b1;
      tick(1);
      i_reg_rd = 1'b0;
      chk(0, e);
      tick(1);
   endtask

   task automatic final_report;
      $display("Checks %0d, errors %0d", num_checks, num_errors);
      if (num_errors == 0 && num_checks > 0) begin
         $display("Finished cleanly");
      end else begin
         $display("Finished with errors");
      end
      $finish;
   endtask

   // Watcher: takes every pending note, oldest first, and compares each against the selected output
   always begin
      @(look);
      while (sel_q.size() > 0) begin
         sel = sel_q.pop_front();
         exp_v = exp_q.pop_front();
         case (sel)
            0: got = o_reg_rdata;
            1: got = {16'h0, o_gate_on};
            2: got = {16'h0, o_ds_monitor_flag};
            3: got = {22'h0, o_fso_on};
            4: got = {22'h0, o_rl_sink};
            5: got = {22'h0, o_rl_resistive};
            6: got = {22'h0, o_safety_sink_overcurrent};
            7: got = {8'h0, o_hs_cur_ua[0]};
            8: got = {16'h0, o_hs_src_on};
            10: got = {8'h0, o_hs_cur_ua[1]};
            default: got = {22'h0, o_sink_slew};
         endcase
         num_checks++;
         if (got !== exp_v) begin
            num_errors++;
            $display("BAD t=%0t sel=%0d exp=%h got=%h", $time, sel, exp_v, got);
         end
      end
   end

   // Hang guard, well beyond the roughly 10k cycles the sequence needs
   initial begin
      #400000;
      num_errors++;
      final_report;
   end

   initial begin
      void'($urandom(32'h288b));
      i_bridge_b_lock_time = 4'($urandom_range(15));
      tick(10);
      i_sys_rst = 1'b0;
      i_bridge_enable_bit = 2'h3;
      reg_rd(hbridge_prot_pkg::ADDR_GEN, 24'h000001);
      reg_rd(hbridge_prot_pkg::ADDR_CFG, 24'h000000);
      reg_rd(hbridge_prot_pkg::ADDR_WAKE, 24'h000000);
      reg_rd(7'h20, 24'h000000);
      reg_wr(hbridge_prot_pkg::ADDR_CFG, 24'h000010);
      tick(2);
      chk(3, 24'h3);
      reg_rd(hbridge_prot_pkg::ADDR_CFG, 24'h000010);
      reg_wr(hbridge_prot_pkg::ADDR_CFG, 24'h0);
      // Slew current: zero code plus random nonzero codes
      for (int k = 0; k < 4; k++) begin
         code = (k == 0) ? 5'h0 : 5'($urandom_range(31, 1));
         i_slew_code[0] = code;
         i_drv_cmd = 8'h01;
         tick(6);
         chk(7, 24'(code * (IMAX / 31)));
         chk(8, {23'h0, code != 5'h0});
         slope_done = 8'h01;
         tick(2);
         chk(8, 24'h0);
         slope_done = 8'h00;
         i_drv_cmd = 8'h00;
         tick(3);
      end
      i_bridge_a_lock_time = 4'h3;
      i_drv_cmd = 8'h04;
      tick(3 * LSTEP);
      chk(1, 24'h0);
      tick(1);
      chk(1, 24'h4);
      i_drv_cmd = 8'h00;
      i_bridge_a_lock_time = 4'h0;
      tick(3);
      // PWM leg: high side after the rise lock, then two locks before the low side takes over
      i_bridge_a_lock_time = 4'h2;
      i_pwm_mode = 2'h1;
      i_bridge_pwm_input = 2'h1;
      tick(5);
      chk(1, 24'h0);
      tick(2);
      chk(1, 24'h1);
      i_bridge_pwm_input = 2'h0;
      tick(5);
      chk(1, 24'h1);
      tick(3);
      chk(1, 24'h0);
      tick(4);
      chk(1, 24'h2);
      i_pwm_mode = 2'h0;
      i_bridge_a_lock_time = 4'h0;
      tick(3);
      // Drain-source trip: a short burst under the filter must not trip
      i_drv_cmd = 8'h01;
      tick(4);
      short_en = 8'h01;
      tick(5);
      short_en = 8'h00;
      tick(2);
      chk(2, 24'h0);
      short_en = 8'h01;
      tick(DSF + 6);
      chk(2, 24'h1);
      chk(1, 24'h0);
      short_en = 8'h00;
      tick(10);
      chk(1, 24'h0);
      i_ds_clr = 8'h01;
      tick(1);
      i_ds_clr = 8'h00;
      tick(4);
      chk(2, 24'h0);
      chk(1, 24'h1);
      i_drv_cmd = 8'h00;
      tick(2);
      // Off-state test: low-side flag only, then refused in dual mode
      low_en = 8'h02;
      i_offstate_test_h1_l2 = 2'h1;
      tick(OLF + 4);
      chk(2, 24'h2);
      chk(5, 24'h1);
      i_offstate_test_h1_l2 = 2'h0;
      low_en = 8'h00;
      // Let the filter drain first, else a set in the clear cycle wins
      tick(1);
      i_ds_clr = 8'hff;
      tick(1);
      i_ds_clr = 8'h00;
      reg_wr(hbridge_prot_pkg::ADDR_CFG, 24'h000001);
      low_en = 8'h02;
      i_offstate_test_h2_l1 = 2'h1;
      tick(OLF + 4);
      chk(2, 24'h0);
      i_offstate_test_h2_l1 = 2'h0;
      low_en = 8'h00;
      reg_wr(hbridge_prot_pkg::ADDR_CFG, 24'h0);
      // Each failure source in turn, slew control on for both bridges
      i_slew_code = {5'h5, 5'h5};
      for (int f = 0; f < 3; f++) begin
         chk(5, 24'h0);
         {i_thermal_shutdown_one, i_pump_low_flag, i_invalid_command_flag} = 3'h4 >> f;
         tick(3);
         chk(4, 24'h3);
         chk(9, 24'h3);
         chk(10, 24'(5 * (IMAX / 31)));
         tick(3200);
         chk(4, 24'h0);
         chk(5, 24'h3);
         {i_thermal_shutdown_one, i_pump_low_flag, i_invalid_command_flag} = 3'h0;
         tick(3);
      end
      i_vs_ov = 1'b1;
      tick(3);
      chk(1, 24'h0000aa);
      i_vs_ov = 1'b0;
      tick(3);
      chk(1, 24'h0);
      reg_wr(hbridge_prot_pkg::ADDR_GEN, 24'h0);
      i_vs_ov = 1'b1;
      tick(3);
      chk(1, 24'h0);
      i_vs_ov = 1'b0;
      reg_rd(hbridge_prot_pkg::ADDR_GEN, 24'h0);
      reg_wr(hbridge_prot_pkg::ADDR_GEN, 24'h000001);
      // Frozen clock enable: a write must not land
      i_ce = 1'b0;
      reg_wr(hbridge_prot_pkg::ADDR_GEN, 24'h0);
      i_ce = 1'b1;
      reg_rd(hbridge_prot_pkg::ADDR_GEN, 24'h000001);
      // Silent failure lines, then both sinks held in current limit
      man_en = 1'b0;
      tick(4 * MHALF + 4);
      chk(3, 24'h3);
      i_fso_ilim = 2'h3;
      tick(FSOF + 4);
      chk(3, 24'h0);
      chk(6, 24'h3);
      i_fso_ilim = 2'h0;
      i_fso_oc_clr = 2'h3;
      tick(1);
      i_fso_oc_clr = 2'h0;
      tick(2);
      chk(6, 24'h0);
      man_en = 1'b1;
      i_standby = 1'b1;
      tick(3);
      chk(3, 24'h3);
      i_vs_ov = 1'b1;
      tick(3);
      i_vs_ov = 1'b0;
      tick(2);
      reg_rd(hbridge_prot_pkg::ADDR_WAKE, 24'h000001);
      reg_rd(hbridge_prot_pkg::ADDR_WAKE, 24'h0);
      tick(2);
      final_report;
   end
endmodule
